// >>> load_ctl_pkg.sv
// shared constants and types of the dc load control arbiter
package load_ctl_pkg;
    // apb register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_INTERVAL = 8'h0c;
    localparam logic [7:0] ADDR_FILE = 8'h10;
    localparam logic [7:0] ADDR_SET_U = 8'h14;
    localparam logic [7:0] ADDR_SET_I = 8'h18;
    localparam logic [7:0] ADDR_SET_P = 8'h1c;
    localparam logic [7:0] ADDR_SET_R = 8'h20;
    // ctrl fields
    localparam int CTRL_ALLOW = 0;
    localparam int CTRL_LOCK = 1;
    localparam int CTRL_LOG_EN = 2;
    localparam int CTRL_LOG_MAN = 3;
    localparam int CTRL_RMODE = 4;
    // cmd fields, write one to act
    localparam int CMD_REM_REQ = 0;
    localparam int CMD_REM_REL = 1;
    localparam int CMD_ON = 2;
    localparam int CMD_OFF = 3;
    localparam int CMD_LOG_START = 4;
    localparam int CMD_LOG_STOP = 5;
    localparam int CMD_UNLOCK = 6;
    localparam int CMD_CLR = 7;
    // reset values and file limits
    localparam logic [15:0] INTERVAL_RESET = 16'h03e8;
    localparam logic [10:0] FILE_FIRST = 11'h001;
    localparam logic [10:0] FILE_MAX = 11'h400;
    localparam logic [33:0] FILE_BYTES_MAX = 34'h1_0000_0000;
    // timing and record size
    localparam int CLK_PERIOD_NS = 5;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int REC_BYTES = 128;

    typedef enum logic [2:0] {
        OWN_PANEL = 3'b001,
        OWN_ANALOG = 3'b010,
        OWN_DIGITAL = 3'b100
    } own_t;

    typedef enum logic [1:0] {
        LG_IDLE = 2'b01,
        LG_RUN = 2'b10
    } log_state_t;

    typedef enum logic [1:0] {
        LOC_MANUAL = 2'b00,
        LOC_REMOTE = 2'b01,
        LOC_LOCAL = 2'b10
    } loc_t;

    typedef struct packed {
        logic [15:0] u;
        logic [15:0] i;
        logic [15:0] p;
        logic [15:0] r;
    } meas_t;

    typedef struct packed {
        meas_t set;
        meas_t act;
        logic r_valid;
        logic r_mode;
        logic input_on;
        logic [1:0] reg_mode;
        logic alarm;
        logic [31:0] time_ms;
    } log_rec_t;
endpackage

// >>> pin_sync.sv
// three stage pin synchroniser, output moves when stages two and three agree
`timescale 1ns/10ps
module pin_sync import load_ctl_pkg::*; #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lv;
    } sync_st_t;

    sync_st_t q;
    sync_st_t d;

    // first stage feeds only the second
    always_comb begin
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.lv = q.lv;
        for (int b = 0; b < W; b++) begin
            if (q.s2[b] == q.s3[b]) begin
                d.lv[b] = q.s3[b];
            end
        end
        if (rst) begin
            d = '0;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign level = q.lv;
endmodule

// >>> log_record.sv
// captures one log record snapshot when asked
`timescale 1ns/10ps
module log_record import load_ctl_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic take,
    input wire meas_t set,
    input wire meas_t act,
    input wire logic r_mode,
    input wire logic input_on,
    input wire logic [1:0] reg_mode,
    input wire logic alarm,
    input wire logic [31:0] time_ms,
    output log_rec_t rec,
    output logic rec_valid
);
    typedef struct packed {
        log_rec_t rec;
        logic vld;
    } rec_st_t;

    rec_st_t q;
    rec_st_t d;

    // resistance fields read zero and flagged invalid outside r mode
    always_comb begin
        d = q;
        d.vld = take;
        if (take) begin
            d.rec.set = set;
            d.rec.act = act;
            d.rec.r_valid = r_mode;
            if (!r_mode) begin
                d.rec.set.r = 16'h0;
                d.rec.act.r = 16'h0;
            end
            d.rec.r_mode = r_mode;
            d.rec.input_on = input_on;
            d.rec.reg_mode = reg_mode;
            d.rec.alarm = alarm;
            d.rec.time_ms = time_ms;
        end
        if (rst) begin
            d = '0;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign rec = q.rec;
    assign rec_valid = q.vld;
endmodule

// >>> load_ctl.sv
// dc load control location arbiter, input switching and usb logger control
`timescale 1ns/10ps
// How it works
// - front button toggles input unless alarm or remote forbids
// - locked panel ignores button and raises an unlock prompt
// - standby inhibit refuses input on in manual or digital control
// - only one remote source owns control at a time
// - digital request during analog takeover is denied with error
// - analog takeover ignored while digital interface holds control
// - status and values stay readable whoever owns control
// - location shown as manual, remote or local
// - clearing allow remote enters local and blocks remote control
// - local ends digital session; host must request again
// - local suspends analog control; resumes if takeover still held
// - set values kept unchanged on entering remote control
// - follow mode starts logging on every input switch on
// - manual mode starts only on menu commands; stops on a menu command, log failure or full file
// - manual stop, or input off in follow mode, closes the log file
// - logging failure raises an error flag
// - record holds set, actual, modes, input, alarm and elapsed time
// - resistance fields only valid in resistance regulation mode
// - every start opens a new numbered file, counter from one
// - one log file never exceeds four gigabytes
// - at most 1024 log files are created
// - follow mode stops on alarm input off; manual logs through
module load_ctl import load_ctl_pkg::*; #(
    parameter int CYCLES_PER_MS = CYC_PER_MS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic front_button,
    input wire logic analog_takeover_n,
    input wire logic analog_input_on,
    input wire logic standby_inhibit_pin,
    input wire meas_t analog_set,
    input wire meas_t actual,
    input wire logic [1:0] reg_mode,
    input wire logic alarm_active,
    input wire logic log_fail,
    output logic dc_input_on,
    output loc_t location,
    output logic unlock_prompt,
    output logic inhibit_notice,
    output logic log_active,
    output logic log_error,
    output logic log_open,
    output logic log_close,
    output logic [10:0] log_file_num,
    output log_rec_t log_rec,
    output logic log_rec_valid
);
    typedef struct packed {
        logic allow;
        logic lock;
        logic log_en;
        logic log_man;
        logic rmode;
        own_t own;
        loc_t loc;
        logic input_on;
        logic in_prev;
        logic btn_prev;
        logic unlock_req;
        logic inhibit_note;
        logic denied;
        logic log_err;
        log_state_t lg;
        logic [15:0] interval;
        logic [15:0] ivl_cnt;
        logic [10:0] file_next;
        logic [10:0] file_cur;
        logic [33:0] bytes;
        logic [31:0] ms_div;
        logic [31:0] time_ms;
        meas_t set;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic open;
        logic close;
        logic take;
    } ctl_st_t;

    ctl_st_t q;
    ctl_st_t d;
    logic [3:0] pins;
    logic btn;
    logic takeover;
    logic ana_on;
    logic inhibit;
    logic [31:0] rd;
    logic map_ok;
    logic acc;
    logic wr;
    logic [7:0] cmd;
    logic deny;
    logic ctl_err;
    logic start;
    logic stop;
    logic [33:0] bytes_next;

    // all pins from outside the clock domain
    pin_sync #(.W(4)) u_sync (
        .clk(clk),
        .rst(rst),
        // takeover enters inverted so the reset level of the stages means released
        .pin({front_button, !analog_takeover_n, analog_input_on, standby_inhibit_pin}),
        .level(pins)
    );

    assign btn = pins[3];
    assign takeover = pins[2];
    assign ana_on = pins[1];
    assign inhibit = pins[0];

    // register read mux, status never refused
    always_comb begin
        rd = 32'h0;
        map_ok = 1'b1;
        case (paddr)
            ADDR_CTRL: rd = {27'h0, q.rmode, q.log_man, q.log_en, q.lock, q.allow};
            ADDR_CMD: rd = 32'h0;
            ADDR_STATUS: rd = {21'h0, alarm_active, q.denied, q.inhibit_note,
                q.unlock_req, q.log_err, q.lg == LG_RUN, q.own == OWN_ANALOG,
                q.own == OWN_DIGITAL, q.input_on, q.loc};
            ADDR_INTERVAL: rd = {16'h0, q.interval};
            ADDR_FILE: rd = {5'h0, q.file_cur, 5'h0, q.file_next};
            ADDR_SET_U: rd = {16'h0, q.set.u};
            ADDR_SET_I: rd = {16'h0, q.set.i};
            ADDR_SET_P: rd = {16'h0, q.set.p};
            ADDR_SET_R: rd = {16'h0, q.set.r};
            default: map_ok = 1'b0;
        endcase
    end

    // a write acts only at the edge that samples pready high
    assign acc = psel && penable && q.pready;
    assign wr = acc && pwrite;
    assign cmd = (wr && paddr == ADDR_CMD) ? pwdata[7:0] : 8'h00;
    // remote request refused while analog holds or remote is locked out
    assign deny = pwdata[CMD_REM_REQ]
        && (takeover || !q.allow || q.own == OWN_ANALOG);
    // input commands from a bus that does not own control are refused
    assign ctl_err = q.own != OWN_DIGITAL && (pwdata[CMD_ON] || pwdata[CMD_OFF]);
    assign bytes_next = q.bytes + 34'(REC_BYTES);

    // next state of the whole block
    always_comb begin
        d = q;
        d.open = 1'b0;
        d.close = 1'b0;
        d.take = 1'b0;
        start = 1'b0;
        stop = 1'b0;

        // apb: one wait cycle then pready for one cycle
        d.pready = psel && penable && !q.pready;
        if (psel && penable && !q.pready) begin
            d.prdata = pwrite ? 32'h0 : rd;
            d.pslverr = !map_ok
                || (pwrite && paddr == ADDR_STATUS)
                || (pwrite && paddr == ADDR_CMD && (deny || ctl_err));
        end

        // clears go first so a same cycle event still sets the flag
        if (cmd[CMD_CLR]) begin
            d.denied = 1'b0;
            d.inhibit_note = 1'b0;
            d.log_err = 1'b0;
        end
        if (cmd[CMD_UNLOCK]) begin
            d.lock = 1'b0;
            d.unlock_req = 1'b0;
        end

        // configuration writes
        if (wr) begin
            unique case (paddr)
                ADDR_CTRL: begin
                    d.allow = pwdata[CTRL_ALLOW];
                    d.lock = pwdata[CTRL_LOCK];
                    d.log_en = pwdata[CTRL_LOG_EN];
                    d.log_man = pwdata[CTRL_LOG_MAN];
                    d.rmode = pwdata[CTRL_RMODE];
                end
                ADDR_INTERVAL: d.interval = pwdata[15:0];
                ADDR_FILE: begin
                    // software skips numbers of files already on the stick
                    if (pwdata[10:0] != 11'h000) begin
                        d.file_next = pwdata[10:0];
                    end
                end
                ADDR_SET_U: d.set.u = pwdata[15:0];
                ADDR_SET_I: d.set.i = pwdata[15:0];
                ADDR_SET_P: d.set.p = pwdata[15:0];
                ADDR_SET_R: d.set.r = pwdata[15:0];
                default: ;
            endcase
        end

        // control ownership, a single one-hot owner
        unique case (q.own)
            OWN_PANEL: begin
                if (q.allow && takeover) begin
                    d.own = OWN_ANALOG;
                end else if (q.allow && cmd[CMD_REM_REQ]) begin
                    d.own = OWN_DIGITAL;
                end
            end
            OWN_ANALOG: begin
                if (!q.allow || !takeover) begin
                    d.own = OWN_PANEL;
                end
            end
            OWN_DIGITAL: begin
                // takeover pin has no say here
                if (!q.allow) begin
                    d.own = OWN_PANEL;
                end else if (cmd[CMD_REM_REL]) begin
                    d.own = OWN_PANEL;
                end
            end
            default: d.own = OWN_PANEL;
        endcase
        if (cmd[CMD_REM_REQ] && deny) begin
            d.denied = 1'b1;
        end
        // set values untouched by any change of owner
        d.set = d.set;

        // displayed location follows the owner and the allow setting
        if (!d.allow) begin
            d.loc = LOC_LOCAL;
        end else if (d.own != OWN_PANEL) begin
            d.loc = LOC_REMOTE;
        end else begin
            d.loc = LOC_MANUAL;
        end

        // front button, only under panel control
        d.btn_prev = btn;
        if (btn && !q.btn_prev && q.own == OWN_PANEL) begin
            if (q.lock) begin
                d.unlock_req = 1'b1;
            end else if (!alarm_active) begin
                if (q.input_on) begin
                    d.input_on = 1'b0;
                end else if (inhibit) begin
                    d.inhibit_note = 1'b1;
                end else begin
                    d.input_on = 1'b1;
                end
            end
        end

        // digital interface switching
        if (q.own == OWN_DIGITAL) begin
            if (cmd[CMD_OFF]) begin
                d.input_on = 1'b0;
            end else if (cmd[CMD_ON] && inhibit) begin
                d.inhibit_note = 1'b1;
            end else if (cmd[CMD_ON] && !alarm_active) begin
                d.input_on = 1'b1;
            end
        end

        // analog interface drives the input as a level
        if (q.own == OWN_ANALOG) begin
            d.input_on = ana_on && !inhibit && !alarm_active;
        end

        // an alarm always takes the input off
        if (alarm_active) begin
            d.input_on = 1'b0;
        end

        // logger
        d.in_prev = q.input_on;
        unique case (q.lg)
            LG_IDLE: begin
                if (q.log_man) begin
                    start = q.log_en && cmd[CMD_LOG_START];
                end else begin
                    start = q.log_en && q.input_on && !q.in_prev;
                end
                if (start && q.file_next > FILE_MAX) begin
                    d.log_err = 1'b1;
                end else if (start) begin
                    d.lg = LG_RUN;
                    d.open = 1'b1;
                    d.file_cur = q.file_next;
                    d.file_next = q.file_next + 11'h001;
                    d.time_ms = 32'h0;
                    d.ms_div = 32'h0;
                    d.ivl_cnt = 16'h0;
                    d.bytes = 34'h0;
                end
            end
            LG_RUN: begin
                if (q.log_man) begin
                    stop = cmd[CMD_LOG_STOP];
                end else begin
                    stop = !q.input_on;
                end
                if (stop || log_fail || !q.log_en) begin
                    d.lg = LG_IDLE;
                    d.close = 1'b1;
                    if (log_fail) begin
                        d.log_err = 1'b1;
                    end
                end else if (q.ms_div == 32'(CYCLES_PER_MS - 1)) begin
                    d.ms_div = 32'h0;
                    d.time_ms = q.time_ms + 32'h1;
                    if (q.ivl_cnt + 16'h1 >= q.interval) begin
                        d.ivl_cnt = 16'h0;
                        if (bytes_next > FILE_BYTES_MAX) begin
                            // file full: close rather than write past the limit
                            d.lg = LG_IDLE;
                            d.close = 1'b1;
                            d.log_err = 1'b1;
                        end else begin
                            d.take = 1'b1;
                            d.bytes = bytes_next;
                        end
                    end else begin
                        d.ivl_cnt = q.ivl_cnt + 16'h1;
                    end
                end else begin
                    d.ms_div = q.ms_div + 32'h1;
                end
            end
        endcase

        if (rst) begin
            d = '0;
            d.allow = 1'b1;
            d.own = OWN_PANEL;
            d.loc = LOC_MANUAL;
            d.lg = LG_IDLE;
            d.interval = INTERVAL_RESET;
            d.file_next = FILE_FIRST;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    // record snapshot; analog set values stand while analog owns
    log_record u_rec (
        .clk(clk),
        .rst(rst),
        .take(q.take),
        .set(q.own == OWN_ANALOG ? analog_set : q.set),
        .act(actual),
        .r_mode(q.rmode),
        .input_on(q.input_on),
        .reg_mode(reg_mode),
        .alarm(alarm_active),
        .time_ms(q.time_ms),
        .rec(log_rec),
        .rec_valid(log_rec_valid)
    );

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign dc_input_on = q.input_on;
    assign location = q.loc;
    assign unlock_prompt = q.unlock_req;
    assign inhibit_notice = q.inhibit_note;
    assign log_active = q.lg[1]; // one-hot run bit, straight from the flop
    assign log_error = q.log_err;
    assign log_open = q.open;
    assign log_close = q.close;
    assign log_file_num = q.file_cur;
endmodule

// >>> load_ctl_checker.sv
// concurrent checks of the load control arbiter at its top ports
`timescale 1ns/10ps
module load_ctl_checker import load_ctl_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic alarm_active,
    input wire logic log_fail,
    input wire logic dc_input_on,
    input wire loc_t location,
    input wire logic unlock_prompt,
    input wire logic log_active,
    input wire logic log_error,
    input wire logic log_open,
    input wire logic log_close,
    input wire log_rec_t log_rec,
    input wire logic log_rec_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [4:0] ctrl_q;
    logic [4:0] ctrl_d;
    logic follow;
    // shadow of the control word; the logging mode is not visible at the ports
    always_comb begin
        ctrl_d = ctrl_q;
        if (psel && penable && pready && pwrite && paddr == ADDR_CTRL) begin
            ctrl_d = pwdata[4:0];
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= 5'h01;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end
    assign follow = ctrl_q[CTRL_LOG_EN] && !ctrl_q[CTRL_LOG_MAN];
    // steps of an apb access and of a write that clears allow remote
    sequence access_start_s;
        psel && $rose(penable);
    endsequence
    sequence one_wait_s;
        !pready ##1 pready;
    endsequence
    sequence clear_allow_s;
        psel && penable && pready && pwrite && paddr == ADDR_CTRL && !pwdata[CTRL_ALLOW];
    endsequence
    wait_state_a: assert property (access_start_s |-> one_wait_s)
        else $error("apb answer not after one wait state");
    status_read_a: assert property (pready && !pwrite && paddr == ADDR_STATUS |-> !pslverr)
        else $error("status read refused");
    loc_legal_a: assert property (location != 2'b11)
        else $error("location code illegal");
    local_entry_a: assert property (clear_allow_s |-> ##[1:3] location == LOC_LOCAL)
        else $error("local not entered");
    alarm_off_a: assert property (alarm_active [*3] |-> !dc_input_on)
        else $error("input on during alarm");
    follow_open_a: assert property ($rose(dc_input_on) && follow && !log_active && !log_error
        |-> ##[1:2] log_open)
        else $error("follow mode did not open log");
    follow_close_a: assert property ($fell(dc_input_on) && follow && log_active
        |-> ##[0:2] log_close)
        else $error("follow mode did not close log");
    manual_keep_a: assert property ($fell(dc_input_on) && ctrl_q[CTRL_LOG_MAN] && log_active
        |=> log_active)
        else $error("manual log stopped on input off");
    res_na_a: assert property (log_rec_valid && !log_rec.r_mode |-> !log_rec.r_valid
        && log_rec.set.r == 16'h0000 && log_rec.act.r == 16'h0000)
        else $error("resistance fields written outside r mode");
    fail_flag_a: assert property (log_fail && log_active |-> ##[1:2] log_error)
        else $error("log failure not flagged");
    prompt_hold_a: assert property ($rose(unlock_prompt) |-> $stable(dc_input_on))
        else $error("locked press changed input");
endmodule
bind load_ctl load_ctl_checker u_chk (.*);

// >>> analog_ctl_model.sv
// behavioural analog remote controller facing the load's analog pins
`timescale 1ns/10ps
module analog_ctl_model import load_ctl_pkg::*; (
    input wire logic clk,
    input wire logic take,
    input wire logic on,
    output logic analog_takeover_n,
    output logic analog_input_on,
    output meas_t analog_set
);
    // takeover pin idles at its pull-up level so nothing is claimed at power up
    initial begin
        analog_takeover_n = 1'b1;
        analog_input_on = 1'b0;
        analog_set = '{16'h0100, 16'h0200, 16'h0300, 16'h0400};
    end
    // takeover is raised before any on command is honoured by the load
    always @(posedge clk) begin
        analog_takeover_n <= !take;
        analog_input_on <= on && take;
    end
endmodule

// >>> tb.sv
// self-checking bench of the load control arbiter with an analog controller
`timescale 1ns/10ps
module tb import load_ctl_pkg::*;;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic take = 1'b0, aon = 1'b0, front_button = 1'b0, standby_inhibit_pin = 1'b0;
    logic alarm_active = 1'b0, log_fail = 1'b0, err, pready, pslverr;
    logic analog_takeover_n, analog_input_on, dc_input_on, unlock_prompt, inhibit_notice;
    logic log_active, log_error, log_open, log_close, log_rec_valid;
    logic [1:0] reg_mode = 2'b01;
    logic [10:0] log_file_num;
    meas_t analog_set, actual = '{16'h0011, 16'h0022, 16'h0033, 16'h0044};
    loc_t location;
    log_rec_t log_rec;
    int n_mismatch = 0, checks_done = 0, cyc = 0, k;
    // a short millisecond keeps logging intervals to a few cycles
    load_ctl #(.CYCLES_PER_MS(4)) u_dut (.*);
    analog_ctl_model u_ana (.clk, .take, .on(aon), .analog_takeover_n, .analog_input_on,
        .analog_set);
    always #2.5 clk = ~clk;
    // cycle ceiling so a hung handshake still ends in the report
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // request is held until the edge that samples pready high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rg(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    // button held past the pin synchroniser in both levels
    task press;
        front_button <= 1'b1;
        repeat (6) @(posedge clk);
        front_button <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task t_regs;
        rg(ADDR_CTRL);
        chk("ctrl reset", 32'h1, rd);
        rg(ADDR_INTERVAL);
        chk("interval reset", 32'h3e8, rd);
        rg(8'h40);
        chk("unmapped err", 32'h1, err);
        apb(1'b1, ADDR_STATUS, 32'hffff);
        chk("status write err", 32'h1, err);
    endtask
    task t_button;
        press();
        chk("press on", 32'h1, dc_input_on);
        press();
        chk("press off", 32'h0, dc_input_on);
        apb(1'b1, ADDR_CTRL, 32'h3);
        press();
        chk("locked input", 32'h0, dc_input_on);
        chk("unlock prompt", 32'h1, unlock_prompt);
        apb(1'b1, ADDR_CMD, 32'h40);
        apb(1'b1, ADDR_CTRL, 32'h1);
        standby_inhibit_pin <= 1'b1;
        repeat (6) @(posedge clk);
        press();
        chk("inhibited input", 32'h0, dc_input_on);
        chk("inhibit notice", 32'h1, inhibit_notice);
        standby_inhibit_pin <= 1'b0;
        apb(1'b1, ADDR_CMD, 32'h80);
    endtask
    task t_remote;
        apb(1'b1, ADDR_SET_U, 32'h1234);
        apb(1'b1, ADDR_CMD, 32'h1);
        chk("request ok", 32'h0, err);
        take <= 1'b1;
        repeat (8) @(posedge clk);
        rg(ADDR_STATUS);
        chk("remote loc", LOC_REMOTE, rd[1:0]);
        chk("analog ignored", 32'h0, rd[4]);
        rg(ADDR_SET_U);
        chk("set kept", 32'h1234, rd);
        apb(1'b1, ADDR_CMD, 32'h2);
        rg(ADDR_STATUS);
        chk("analog owner", 32'h1, rd[4]);
        chk("digital dropped", 32'h0, rd[3]);
        apb(1'b1, ADDR_CMD, 32'h1);
        chk("request denied", 32'h1, err);
        rg(ADDR_STATUS);
        chk("status readable", 32'h0, err);
    endtask
    task t_local;
        apb(1'b1, ADDR_CTRL, 32'h0);
        rg(ADDR_STATUS);
        chk("local loc", LOC_LOCAL, rd[1:0]);
        chk("analog paused", 32'h0, rd[4]);
        apb(1'b1, ADDR_CTRL, 32'h1);
        rg(ADDR_STATUS);
        chk("analog resumed", 32'h1, rd[4]);
        take <= 1'b0;
        repeat (8) @(posedge clk);
        apb(1'b1, ADDR_CMD, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h1);
        rg(ADDR_STATUS);
        chk("session ended", 32'h0, rd[3]);
        chk("manual loc", LOC_MANUAL, rd[1:0]);
        apb(1'b1, ADDR_CMD, 32'h4);
        chk("on refused", 32'h1, err);
    endtask
    task t_log;
        apb(1'b1, ADDR_INTERVAL, 32'h2);
        apb(1'b1, ADDR_CTRL, 32'h5);
        front_button <= 1'b1;
        while (log_open !== 1'b1) @(posedge clk);
        chk("follow open", 32'h1, log_open);
        chk("first file", 32'h1, log_file_num);
        front_button <= 1'b0;
        while (log_rec_valid !== 1'b1) @(posedge clk);
        chk("rec set u", 32'h1234, log_rec.set.u);
        chk("rec act u", 32'h0011, log_rec.act.u);
        chk("rec input", 32'h1, log_rec.input_on);
        chk("rec r na", 32'h0, log_rec.r_valid);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (log_rec_valid !== 1'b1 && k < 40);
        chk("rec spacing", 32'd8, k);
        alarm_active <= 1'b1;
        while (log_close !== 1'b1) @(posedge clk);
        chk("alarm close", 32'h1, log_close);
        alarm_active <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'hd);
        press();
        chk("manual no start", 32'h0, log_active);
        apb(1'b1, ADDR_CMD, 32'h10);
        while (log_open !== 1'b1) @(posedge clk);
        chk("second file", 32'h2, log_file_num);
        alarm_active <= 1'b1;
        repeat (4) @(posedge clk);
        alarm_active <= 1'b0;
        chk("alarm off", 32'h0, dc_input_on);
        chk("manual logs on", 32'h1, log_active);
        // stop by command first, then restart so the failure hits a running log
        apb(1'b1, ADDR_CMD, 32'h20);
        while (log_close !== 1'b1) @(posedge clk);
        chk("manual stop", 32'h1, log_close);
        apb(1'b1, ADDR_CMD, 32'h10);
        log_fail <= 1'b1;
        repeat (3) @(posedge clk);
        log_fail <= 1'b0;
        chk("log error", 32'h1, log_error);
        chk("fail stop", 32'h0, log_active);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_button();
        t_remote();
        t_local();
        t_log();
        complete_run();
    end
endmodule
